// *** fuse_lp_regs.svh ***
// Register offsets, field positions, reset values and codes for the bank.
`ifndef FUSE_LP_REGS_SVH
`define FUSE_LP_REGS_SVH

// ============================================================
// Register offsets (word addresses on the serial register link)
`define FUSE_TRIGGER_OFFSET      7'h53
`define RESERVED_ZERO_OFFSET     7'h54
`define LOWPOWER_THRESH_OFFSET   7'h55
`define REG_DRIVE_CTL_OFFSET     7'h56

// ============================================================
// Field positions
`define FUSE_CODE_MSB            7
`define FUSE_CODE_LSB            0
`define THRESH_MSB               14
`define THRESH_LSB               0
`define GAIN_MSB                 9
`define GAIN_LSB                 7
`define TEMPCO_MSB               6
`define TEMPCO_LSB               4
`define SUPPLYCO_MSB             3
`define SUPPLYCO_LSB             1
`define CTL_RSVD_HI_BIT          10
`define CTL_RSVD_LO_BIT          0

// ============================================================
// Codes and reset values
`define FUSE_TRIGGER_CODE        8'hfb
`define FUSE_TRIGGER_RESET       8'h00
`define RESERVED_ZERO_RESET      16'h0000
`define LOWPOWER_THRESH_RESET    15'h0000
`define SELECT_FIELD_RESET       3'h0

`endif

// *** fuse_lp_pkg.sv ***
// Types shared by the fuse trigger and low-power threshold bank.
package fuse_lp_pkg;

  // Selects which register a link access addresses.
  typedef enum logic [2:0] {
    sel_none,
    sel_fuse,
    sel_reserved,
    sel_thresh,
    sel_drive
  } reg_select_type;

  // Fast current converter result and low-power threshold.
  typedef logic [14:0] current_code_type;

endpackage

// *** lowpower_compare.sv ***
// Registered compare of the fast current result against the threshold.
`timescale 1ns/100ps
`include "fuse_lp_regs.svh"

module lowpower_compare
  import fuse_lp_pkg::*;
(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // Compare inputs
  input  wire current_code_type threshold,
  input  wire current_code_type fast_current_converter,
  input  wire logic             fast_current_valid,
  // Result
  output logic                  lowpower_entry_request
);

  logic below_d;
  logic below_q;

  // A new result below the threshold asks for low power; a zero
  // threshold never does, since no code can be below it.
  always_comb begin
    below_d = below_q;
    if (fast_current_valid) begin
      below_d = (fast_current_converter < threshold);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      below_q <= 1'b0;
    end else begin
      below_q <= below_d;
    end
  end

  assign lowpower_entry_request = below_q;

endmodule

// *** fuse_trigger_lowpower_threshold_regs.sv ***
// Fuse trigger, reserved word, low-power threshold and drive control.
`timescale 1ns/100ps
`include "fuse_lp_regs.svh"

module fuse_trigger_lowpower_threshold_regs
  import fuse_lp_pkg::*;
(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // Register access from the serial link decoder
  input  wire logic [6:0]       reg_addr,
  input  wire logic             reg_write,
  input  wire logic             reg_read,
  input  wire logic [15:0]      reg_wdata,
  output logic      [15:0]      reg_rdata,
  output logic                  reg_hit,
  // Fast current converter
  input  wire current_code_type fast_current_converter,
  input  wire logic             fast_current_valid,
  // Fault algorithm status, deliberately not used by the fuse path
  input  wire logic             fault_detected,
  // Outputs to the analog and mode logic
  output logic                  fuse_blow_pulse,
  output logic                  lowpower_entry_request,
  output current_code_type      lowpower_entry_threshold,
  output logic      [2:0]       base_drive_gain_select,
  output logic      [2:0]       temperature_coefficient_select,
  output logic      [2:0]       supply_coefficient_select,
  output logic                  reserved_word_nonzero
);

  // ============================================================
  // Address decode
  reg_select_type sel;

  // Decode the word address into a register select. Any address outside
  // the four words of this slice selects nothing, so a write there is
  // dropped and a read there returns zero.
  always_comb begin
    case (reg_addr)
      `FUSE_TRIGGER_OFFSET:    sel = sel_fuse;
      `RESERVED_ZERO_OFFSET:   sel = sel_reserved;
      `LOWPOWER_THRESH_OFFSET: sel = sel_thresh;
      `REG_DRIVE_CTL_OFFSET:   sel = sel_drive;
      default:                 sel = sel_none;
    endcase
  end

  // Tells the link decoder that this slice owns the address. It is
  // combinational so that the decoder can steer the answer in the same
  // cycle; it carries no state and needs no reset.
  assign reg_hit = (sel != sel_none);

  // ============================================================
  // Register state
  //
  // Fuse trigger word: bits 7 to 0 hold the last code written; bits 15
  // to 8 are not stored and read as zero. Only the trigger code starts
  // a blow, and the blow itself is a one-cycle pulse to the fuse driver.
  //
  // Reserved word: all 16 bits are stored and read back. The host keeps
  // it zero; a nonzero value only raises a status level and changes no
  // behaviour here.
  //
  // Threshold word: bits 14 to 0 hold the low-power entry threshold in
  // linear steps of sense voltage, so the full code stands for the top
  // of the converter range. Bit 15 is not stored and reads zero.
  //
  // Drive control word: three 3-bit selects at bits 9 to 7, 6 to 4 and
  // 3 to 1. Bits 10 and 0 are reserved but stored and read back, so a
  // host that reads, modifies and writes the word keeps what it found.
  // Bits 15 to 11 are not stored and read as zero.
  logic [7:0]       fuse_code_q, fuse_code_d;
  logic             fuse_pulse_q, fuse_pulse_d;
  logic [15:0]      reserved_q, reserved_d;
  current_code_type thresh_q, thresh_d;
  logic [2:0]       gain_q, gain_d;
  logic [2:0]       tempco_q, tempco_d;
  logic [2:0]       supplyco_q, supplyco_d;
  logic             ctl_rsvd_hi_q, ctl_rsvd_hi_d;
  logic             ctl_rsvd_lo_q, ctl_rsvd_lo_d;
  logic [15:0]      rdata_q, rdata_d;

  // Next values for every register but the read data. The fuse pulse depends only on
  // the written code, so a fault flag can neither block nor cause it.
  // A write to an unmapped address falls to the default and changes
  // nothing.
  always_comb begin
    fuse_code_d   = fuse_code_q;
    fuse_pulse_d  = 1'b0;
    reserved_d    = reserved_q;
    thresh_d      = thresh_q;
    gain_d        = gain_q;
    tempco_d      = tempco_q;
    supplyco_d    = supplyco_q;
    ctl_rsvd_hi_d = ctl_rsvd_hi_q;
    ctl_rsvd_lo_d = ctl_rsvd_lo_q;
    if (reg_write) begin
      case (sel)
        sel_fuse: begin
          // The whole low byte is kept so that a read shows what the host
          // last sent, trigger code or not.
          fuse_code_d = reg_wdata[`FUSE_CODE_MSB:`FUSE_CODE_LSB];
          fuse_pulse_d = (reg_wdata[`FUSE_CODE_MSB:`FUSE_CODE_LSB]
                          == `FUSE_TRIGGER_CODE);
        end
        sel_reserved: begin
          // Stored as written; host is expected to keep it zero.
          reserved_d = reg_wdata;
        end
        sel_thresh: begin
          // Bit 15 of the written word is dropped here.
          thresh_d = reg_wdata[`THRESH_MSB:`THRESH_LSB];
        end
        sel_drive: begin
          // Reserved bits 10 and 0 are kept as written.
          gain_d        = reg_wdata[`GAIN_MSB:`GAIN_LSB];
          tempco_d      = reg_wdata[`TEMPCO_MSB:`TEMPCO_LSB];
          supplyco_d    = reg_wdata[`SUPPLYCO_MSB:`SUPPLYCO_LSB];
          ctl_rsvd_hi_d = reg_wdata[`CTL_RSVD_HI_BIT];
          ctl_rsvd_lo_d = reg_wdata[`CTL_RSVD_LO_BIT];
        end
        default: begin
          fuse_pulse_d = 1'b0;
        end
      endcase
    end
  end

  // Read data is registered; unused upper bits read as zero.
  // A read and a write in the same cycle return the old contents,
  // because the read mux looks at the registers, not at their next
  // values. The word then stands until the next read strobe, which
  // lets a slow link shift it out at its own pace.
  always_comb begin
    rdata_d = rdata_q;
    if (reg_read) begin
      case (sel)
        sel_fuse:     rdata_d = {8'h00, fuse_code_q};
        sel_reserved: rdata_d = reserved_q;
        sel_thresh:   rdata_d = {1'b0, thresh_q};
        sel_drive:    rdata_d = {5'h00, ctl_rsvd_hi_q, gain_q, tempco_q,
                                 supplyco_q, ctl_rsvd_lo_q};
        default:      rdata_d = 16'h0000;
      endcase
    end
  end

  // Register every field on each edge. All reset values are constants,
  // so the whole slice comes out of reset reading zero.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fuse_code_q   <= `FUSE_TRIGGER_RESET;
      fuse_pulse_q  <= 1'b0;
      reserved_q    <= `RESERVED_ZERO_RESET;
      thresh_q      <= `LOWPOWER_THRESH_RESET;
      gain_q        <= `SELECT_FIELD_RESET;
      tempco_q      <= `SELECT_FIELD_RESET;
      supplyco_q    <= `SELECT_FIELD_RESET;
      ctl_rsvd_hi_q <= 1'b0;
      ctl_rsvd_lo_q <= 1'b0;
      rdata_q       <= 16'h0000;
    end else begin
      fuse_code_q   <= fuse_code_d;
      fuse_pulse_q  <= fuse_pulse_d;
      reserved_q    <= reserved_d;
      thresh_q      <= thresh_d;
      gain_q        <= gain_d;
      tempco_q      <= tempco_d;
      supplyco_q    <= supplyco_d;
      ctl_rsvd_hi_q <= ctl_rsvd_hi_d;
      ctl_rsvd_lo_q <= ctl_rsvd_lo_d;
      rdata_q       <= rdata_d;
    end
  end

  // ============================================================
  // Outputs
  // All but reg_hit and the reserved flag come straight from flip-flops; that flag
  // compares stored bits only, so it moves only after a clock edge.
  assign reg_rdata                      = rdata_q;
  assign fuse_blow_pulse                = fuse_pulse_q;
  assign lowpower_entry_threshold       = thresh_q;
  assign base_drive_gain_select         = gain_q;
  assign temperature_coefficient_select = tempco_q;
  assign supply_coefficient_select      = supplyco_q;
  // Flags a host that broke the zero-only convention.
  assign reserved_word_nonzero          = (reserved_q != 16'h0000);

  // Unused on purpose: the host fuse command overrides fault state.
  // The input stays on the port list so that the integration shows
  // plainly that the fuse path was meant to be independent of it.
  logic unused_fault;
  assign unused_fault = fault_detected;

  // ============================================================
  // Low-power entry compare
  // The compare runs on the stored threshold, so a threshold write takes
  // effect from the next converter result on. The request is a level
  // for the mode logic; leaving low power again is that logic's job.
  // The compare keeps its own result flip-flop, so this module adds no
  // further delay on the request path.
  lowpower_compare u_compare (
    .clock                  (clock),
    .rst_b                  (rst_b),
    .threshold              (thresh_q),
    .fast_current_converter (fast_current_converter),
    .fast_current_valid     (fast_current_valid),
    .lowpower_entry_request (lowpower_entry_request)
  );

endmodule

// *** regs_props.sv ***
// Checker for the fuse trigger and threshold register bank.
`timescale 1ns/100ps
module regs_props
  import fuse_lp_pkg::*;
(
  // Clock, reset, register access, current converter inputs and outputs
  input logic             clock,
  input logic             rst_b,
  input logic [6:0]       reg_addr,
  input logic             reg_write,
  input logic             reg_read,
  input logic [15:0]      reg_wdata,
  input logic [15:0]      reg_rdata,
  input current_code_type fast_current_converter,
  input logic             fast_current_valid,
  input logic             fuse_blow_pulse,
  input logic             lowpower_entry_request,
  input current_code_type lowpower_entry_threshold,
  input logic [2:0]       base_drive_gain_select,
  input logic [2:0]       supply_coefficient_select
);
  // ======
  // Write decodes; only a full strobe with the right address is a cause.
  wire fuse_hit = reg_write && reg_addr == 7'h53 && reg_wdata[7:0] == 8'hfb;
  wire thr_wr   = reg_write && reg_addr == 7'h55;
  wire drv_wr   = reg_write && reg_addr == 7'h56;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence fuse_code_wr;
    fuse_hit;
  endsequence
  fuse_fires_a:
    assert property (fuse_code_wr |=> fuse_blow_pulse) else $error("no pulse");
  fuse_cause_a:
    assert property (fuse_blow_pulse |-> $past(fuse_hit)) else $error("pulse");
  thresh_store_a:
    assert property (thr_wr |=>
      lowpower_entry_threshold == $past(reg_wdata[14:0]))
      else $error("threshold not stored");
  thresh_msb_a:
    assert property (reg_read && reg_addr == 7'h55 |=> !reg_rdata[15])
      else $error("threshold bit 15 set");
  lp_compare_a:
    assert property (fast_current_valid |=> lowpower_entry_request ==
      ($past(fast_current_converter) < $past(lowpower_entry_threshold)))
      else $error("low-power request wrong");
  lp_hold_a:
    assert property (!fast_current_valid |=> $stable(lowpower_entry_request))
      else $error("request moved");
  drive_store_a:
    assert property (drv_wr |=> base_drive_gain_select == $past(reg_wdata[9:7])
      && supply_coefficient_select == $past(reg_wdata[3:1]))
      else $error("drive fields wrong");
endmodule

// *** host_link_model.sv ***
// Host model: one-cycle register strobes launched on falling edges.
`timescale 1ns/100ps
module host_link_model (
  // Clock and register access
  input  logic        clock,
  output logic [6:0]  reg_addr = 7'h00,
  output logic        reg_write = 1'b0,
  output logic        reg_read = 1'b0,
  output logic [15:0] reg_wdata = 16'h0000,
  input  logic [15:0] reg_rdata
);
  // ======
  // Released data is inverted so a stale word never passes as live.
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
    reg_wdata = ~d;
  endtask
  // The answer is registered on the read edge and sampled half a cycle later.
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    d = reg_rdata;
  endtask
endmodule

// *** tb.sv ***
// Self-checking testbench for the fuse and threshold register bank.
`timescale 1ns/100ps
module tb;
  // ======
  // Design and host signals.
  logic        clock = 1'b0, rst_b = 1'b0, fault_detected = 1'b0;
  logic        fast_current_valid = 1'b0, reg_write, reg_read, reg_hit;
  logic        fuse_blow_pulse, lowpower_entry_request, reserved_word_nonzero;
  logic [6:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, v;
  logic [14:0] fast_current_converter = 15'h0000, lowpower_entry_threshold;
  logic [2:0]  base_drive_gain_select, temperature_coefficient_select;
  logic [2:0]  supply_coefficient_select;
  int          error_cnt = 0, n_tests = 0, pulses = 0;
  wire  [15:0] flds = {7'h00, base_drive_gain_select,
                       temperature_coefficient_select,
                       supply_coefficient_select};
  fuse_trigger_lowpower_threshold_regs dut_u (
    .clock                          (clock),
    .rst_b                          (rst_b),
    .reg_addr                       (reg_addr),
    .reg_write                      (reg_write),
    .reg_read                       (reg_read),
    .reg_wdata                      (reg_wdata),
    .reg_rdata                      (reg_rdata),
    .reg_hit                        (reg_hit),
    .fast_current_converter         (fast_current_converter),
    .fast_current_valid             (fast_current_valid),
    .fault_detected                 (fault_detected),
    .fuse_blow_pulse                (fuse_blow_pulse),
    .lowpower_entry_request         (lowpower_entry_request),
    .lowpower_entry_threshold       (lowpower_entry_threshold),
    .base_drive_gain_select         (base_drive_gain_select),
    .temperature_coefficient_select (temperature_coefficient_select),
    .supply_coefficient_select      (supply_coefficient_select),
    .reserved_word_nonzero          (reserved_word_nonzero)
  );
  host_link_model host_u (
    .clock     (clock),
    .reg_addr  (reg_addr),
    .reg_write (reg_write),
    .reg_read  (reg_read),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata)
  );
  // Clock, and a count of fuse pulses since a pulse lasts one cycle only.
  initial forever #20 clock = ~clock;
  always @(posedge clock) if (fuse_blow_pulse === 1'b1) pulses <= pulses + 1;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One current result; the request level is looked at a cycle later.
  task automatic cur(input logic [14:0] c, input logic [15:0] exp);
    @(negedge clock);
    fast_current_converter = c;
    fast_current_valid = 1'b1;
    @(negedge clock);
    fast_current_valid = 1'b0;
    check(16'(lowpower_entry_request), exp);
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [15:0] exp);
    host_u.rd(a, v);
    check(v, exp);
  endtask
  // Hang guard, far beyond the roughly 40 cycles the tests need.
  initial begin
    #200000;
    error_cnt++;
    stop_test;
  end
  // Main sequence of register and current stimulus.
  initial begin
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    for (int a = 'h53; a < 'h58; a++) rdchk(7'(a), 16'h0000);
    check(16'(reg_hit), 16'h0000);
    check(flds, 16'h0000);
    cur(15'h0000, 16'h0000);
    fault_detected = 1'b1;
    host_u.wr(7'h53, 16'h12fb);
    rdchk(7'h53, 16'h00fb);
    check(16'(pulses), 16'h0001);
    host_u.wr(7'h53, 16'h00fa);
    fault_detected = 1'b0;
    rdchk(7'h53, 16'h00fa);
    check(16'(pulses), 16'h0001);
    host_u.wr(7'h55, 16'hffff);
    rdchk(7'h55, 16'h7fff);
    check(16'(reg_hit), 16'h0001);
    check(16'(lowpower_entry_threshold), 16'h7fff);
    host_u.wr(7'h55, 16'h8001);
    cur(15'h0000, 16'h0001);
    cur(15'h0001, 16'h0000);
    host_u.wr(7'h54, 16'h0000);
    check(16'(reserved_word_nonzero), 16'h0000);
    host_u.wr(7'h56, 16'hffff);
    rdchk(7'h56, 16'h07ff);
    host_u.wr(7'h56, 16'h0292);
    check(flds, 16'h0149);
    stop_test;
  end
endmodule
bind fuse_trigger_lowpower_threshold_regs regs_props props_u (
  .clock                     (clock),
  .rst_b                     (rst_b),
  .reg_addr                  (reg_addr),
  .reg_write                 (reg_write),
  .reg_read                  (reg_read),
  .reg_wdata                 (reg_wdata),
  .reg_rdata                 (reg_rdata),
  .fast_current_converter    (fast_current_converter),
  .fast_current_valid        (fast_current_valid),
  .fuse_blow_pulse           (fuse_blow_pulse),
  .lowpower_entry_request    (lowpower_entry_request),
  .lowpower_entry_threshold  (lowpower_entry_threshold),
  .base_drive_gain_select    (base_drive_gain_select),
  .supply_coefficient_select (supply_coefficient_select)
);
